// ==== design/adrc_pkg.sv ====
package adrc_pkg;
  // Clock and device geometry
  localparam int CLOCK_PERIOD_NS = 8;
  localparam int ADDR_WIDTH = 18;
  localparam int HALF_WIDTH = 9;
  localparam int REFRESH_ROWS = 256;
  localparam int ROW_CNT_WIDTH = 8;

  // Timing figures as printed, 100 ns grade
  localparam int POWER_UP_PAUSE_US = 100;
  localparam int WAKE_UP_CYCLES = 8;
  localparam int REFRESH_INTERVAL_MS = 4;
  localparam int CYCLE_TIME_NS = 190;
  localparam int ROW_PRECHARGE_NS = 80;
  localparam int ROW_PULSE_NS = 100;
  localparam int ROW_TO_COLUMN_DELAY_MIN_NS = 25;
  localparam int ROW_TO_COLUMN_DELAY_MAX_NS = 50;
  localparam int ROW_ACCESS_TIME_NS = 100;
  localparam int COLUMN_PULSE_NS = 50;
  localparam int PAGE_COLUMN_PRECHARGE_NS = 30;
  localparam int COLUMN_TO_WRITE_DELAY_NS = 40;
  localparam int ROW_TO_WRITE_DELAY_NS = 90;
  localparam int WRITE_TO_ROW_LEAD_NS = 35;
  localparam int REFRESH_COLUMN_HOLD_NS = 20;
  localparam int COLUMN_SETUP_NS = 15;
  localparam int DATA_HOLD_NS = 35;

  // Least times round up, longest round down
  localparam int RCD_MIN_CYC = (ROW_TO_COLUMN_DELAY_MIN_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RCD_MAX_CYC = ROW_TO_COLUMN_DELAY_MAX_NS / CLOCK_PERIOD_NS;
  localparam int RAS_CYC = (ROW_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RP_CYC = (ROW_PRECHARGE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RC_CYC = (CYCLE_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int CAS_CYC = (COLUMN_PULSE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int CP_CYC = (PAGE_COLUMN_PRECHARGE_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RAC_CYC = (ROW_ACCESS_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int CWD_CYC = (COLUMN_TO_WRITE_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RWD_CYC = (ROW_TO_WRITE_DELAY_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int RWL_CYC = (WRITE_TO_ROW_LEAD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int CHR_CYC = (REFRESH_COLUMN_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int ASC_CYC = (COLUMN_SETUP_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int DH_CYC = (DATA_HOLD_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int POWER_UP_CYC = (POWER_UP_PAUSE_US * 1000 + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
  localparam int REFRESH_SPACING_CYC = (REFRESH_INTERVAL_MS * 1000000 / REFRESH_ROWS) / CLOCK_PERIOD_NS;

  localparam int TIMER_WIDTH = 16;
  localparam logic [TIMER_WIDTH-1:0] TIMER_ZERO = 16'h0000;
  localparam logic [TIMER_WIDTH-1:0] TIMER_ONE = 16'h0001;

  // Command codes from the user
  typedef enum logic [1:0] {
    ADRC_CMD_READ = 2'b00,
    ADRC_CMD_WRITE = 2'b01,
    ADRC_CMD_RMW = 2'b10
  } adrc_cmd_e;

  // Request from the user side
  typedef struct packed {
    adrc_cmd_e cmd;
    logic page;
    logic [ADDR_WIDTH-1:0] addr;
    logic wrData;
  } adrc_req_s;

  // Pins toward the memory
  typedef struct packed {
    logic rowStrobe_n;
    logic colStrobe_n;
    logic writeStrobe_n;
    logic [HALF_WIDTH-1:0] addr;
    logic dataIn;
  } adrc_pins_s;
endpackage

// ==== design/adrc_timer.sv ====
`timescale 1ns/1ns
// Down-counter that flags expiry; load wins over counting
module adrc_timer (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic enable,
  input wire logic load,
  input wire logic [adrc_pkg::TIMER_WIDTH-1:0] loadValue,
  output logic expired
);
  logic [adrc_pkg::TIMER_WIDTH-1:0] count_ff;

  // Counts down to zero and holds there
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= adrc_pkg::TIMER_ZERO;
    end else if (enable) begin
      if (load) begin
        count_ff <= loadValue;
      end else if (count_ff != adrc_pkg::TIMER_ZERO) begin
        count_ff <= count_ff - adrc_pkg::TIMER_ONE;
      end
    end
  end

  // Expiry ignores load: users feed expiry straight back as load
  assign expired = (count_ff == adrc_pkg::TIMER_ZERO);
endmodule

// ==== design/adrc_controller.sv ====
`timescale 1ns/1ns
module adrc_controller #(
  parameter int POWER_UP_CYCLES = adrc_pkg::POWER_UP_CYC,
  parameter int REFRESH_SPACING = adrc_pkg::REFRESH_SPACING_CYC
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  input wire logic reqValid,
  input wire adrc_pkg::adrc_req_s req,
  input wire logic dataOutPin,
  output logic reqReady,
  output logic rdValid,
  output logic rdData,
  output logic initDone,
  output adrc_pkg::adrc_pins_s pins
);
  typedef enum logic [3:0] {
    ST_POWER = 4'b0000,
    ST_WAKE_LOW = 4'b0001,
    ST_WAKE_HIGH = 4'b0010,
    ST_IDLE = 4'b0011,
    ST_ROW = 4'b0100,
    ST_COL = 4'b0101,
    ST_LATE_WE = 4'b0110,
    ST_COL_END = 4'b0111,
    ST_PAGE_PRE = 4'b1000,
    ST_ROW_END = 4'b1001,
    ST_PRECHARGE = 4'b1010,
    ST_REF_CAS = 4'b1011,
    ST_REF_RAS = 4'b1100
  } adrc_state_e;

  adrc_state_e state_ff;
  adrc_state_e nxt_state;
  adrc_pkg::adrc_pins_s pins_ff;
  adrc_pkg::adrc_pins_s nxt_pins;
  adrc_pkg::adrc_req_s req_ff;
  logic [adrc_pkg::TIMER_WIDTH-1:0] step_ff;
  logic [adrc_pkg::TIMER_WIDTH-1:0] nxt_step;
  logic [adrc_pkg::TIMER_WIDTH-1:0] since_ff;
  logic [adrc_pkg::TIMER_WIDTH-1:0] refreshAge_ff;
  logic [3:0] wakeCount_ff;
  logic refreshDue_ff;
  logic reqReady_ff;
  logic rdValid_ff;
  logic rdData_ff;
  logic initDone_ff;
  logic doutMeta_ff;
  logic doutSync_ff;
  logic refreshTick;
  logic accept;
  // Sample reached when a step counter has run n cycles
  function automatic logic reached(input logic [adrc_pkg::TIMER_WIDTH-1:0] cnt, input int n);
    reached = cnt >= adrc_pkg::TIMER_WIDTH'(n - 1);
  endfunction

  // Refresh spacing; a long count so it is a parameter
  adrc_timer refreshTimer (
    .clock(clock),
    .reset_n(reset_n),
    .enable(clockEnable),
    .load(refreshTick),
    .loadValue(adrc_pkg::TIMER_WIDTH'(REFRESH_SPACING - 1)),
    .expired(refreshTick)
  );

  // Data-out pin is asynchronous to us, two stages first
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      doutMeta_ff <= 1'b0;
      doutSync_ff <= 1'b0;
    end else if (clockEnable) begin
      doutMeta_ff <= dataOutPin;
      doutSync_ff <= doutMeta_ff;
    end
  end

  // Evenly spaced distributed refresh, one row per tick
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      refreshDue_ff <= 1'b0;
    end else if (clockEnable) begin
      if (refreshTick && initDone_ff) begin
        refreshDue_ff <= 1'b1;
      end else if (state_ff == ST_REF_CAS) begin
        refreshDue_ff <= 1'b0;
      end
    end
  end

  // Overrun watch: a refresh late beyond one spacing restarts wake-up
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      refreshAge_ff <= adrc_pkg::TIMER_ZERO;
    end else if (clockEnable) begin
      if (state_ff == ST_REF_CAS || !initDone_ff) begin
        refreshAge_ff <= adrc_pkg::TIMER_ZERO;
      end else if (refreshTick) begin
        refreshAge_ff <= refreshAge_ff + adrc_pkg::TIMER_ONE;
      end
    end
  end

  // Cycles since the last row strobe fall, for random spacing
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      since_ff <= adrc_pkg::TIMER_ZERO;
    end else if (clockEnable) begin
      if (pins_ff.rowStrobe_n && !nxt_pins.rowStrobe_n) begin
        since_ff <= adrc_pkg::TIMER_ZERO;
      end else if (since_ff != 16'hFFFF) begin
        since_ff <= since_ff + adrc_pkg::TIMER_ONE;
      end
    end
  end
  assign accept = reqValid && reqReady_ff;

  // Main sequencer: next state, next pins, step counter
  always_comb begin
    nxt_state = state_ff;
    nxt_pins = pins_ff;
    nxt_step = step_ff + adrc_pkg::TIMER_ONE;
    case (state_ff)
      ST_POWER: begin
        if (reached(step_ff, POWER_UP_CYCLES)) begin
          nxt_state = ST_WAKE_LOW;
          nxt_pins.rowStrobe_n = 1'b0;
          nxt_step = adrc_pkg::TIMER_ZERO;
        end
      end
      ST_WAKE_LOW: begin
        if (reached(step_ff, adrc_pkg::RAS_CYC)) begin
          nxt_state = ST_WAKE_HIGH;
          nxt_pins.rowStrobe_n = 1'b1;
          nxt_step = adrc_pkg::TIMER_ZERO;
        end
      end
      ST_WAKE_HIGH: begin
        if (reached(step_ff, adrc_pkg::RP_CYC)) begin
          nxt_step = adrc_pkg::TIMER_ZERO;
          if (wakeCount_ff == 4'(adrc_pkg::WAKE_UP_CYCLES)) begin
            nxt_state = ST_IDLE;
          end else begin
            nxt_state = ST_WAKE_LOW;
            nxt_pins.rowStrobe_n = 1'b0;
          end
        end
      end
      ST_IDLE: begin
        nxt_step = adrc_pkg::TIMER_ZERO;
        // A request already taken must start, else it is lost when refresh falls due
        if (accept && reached(since_ff, adrc_pkg::RC_CYC)) begin
          nxt_state = ST_ROW;
          nxt_pins.rowStrobe_n = 1'b0;
        end else if (refreshAge_ff > adrc_pkg::TIMER_ONE) begin
          nxt_state = ST_WAKE_LOW;
          nxt_pins.rowStrobe_n = 1'b0;
        end else if (refreshDue_ff && reached(since_ff, adrc_pkg::RC_CYC)) begin
          nxt_state = ST_REF_CAS;
          nxt_pins.colStrobe_n = 1'b0;
        end
      end
      ST_ROW: begin
        // Column half goes out once row hold has passed
        if (reached(step_ff, adrc_pkg::ASC_CYC)) begin
          nxt_pins.addr = req_ff.addr[adrc_pkg::HALF_WIDTH-1:0];
          nxt_pins.writeStrobe_n = (req_ff.cmd != adrc_pkg::ADRC_CMD_WRITE);
          nxt_pins.dataIn = req_ff.wrData;
        end
        if (reached(step_ff, adrc_pkg::RCD_MIN_CYC + 1)) begin
          nxt_state = ST_COL;
          nxt_pins.colStrobe_n = 1'b0;
          nxt_step = adrc_pkg::TIMER_ZERO;
        end
      end
      ST_COL: begin
        if (req_ff.cmd == adrc_pkg::ADRC_CMD_RMW && reached(step_ff, adrc_pkg::CWD_CYC)
            && reached(since_ff, adrc_pkg::RWD_CYC)) begin
          nxt_state = ST_LATE_WE;
          nxt_pins.writeStrobe_n = 1'b0;
          nxt_step = adrc_pkg::TIMER_ZERO;
        end else if (req_ff.cmd != adrc_pkg::ADRC_CMD_RMW && reached(step_ff, adrc_pkg::CAS_CYC)
            && reached(since_ff, adrc_pkg::RAC_CYC)) begin
          nxt_state = ST_COL_END;
          nxt_pins.colStrobe_n = 1'b1;
          nxt_step = adrc_pkg::TIMER_ZERO;
        end
      end
      ST_LATE_WE: begin
        if (reached(step_ff, adrc_pkg::DH_CYC) && reached(step_ff, adrc_pkg::RWL_CYC)) begin
          nxt_state = ST_COL_END;
          nxt_pins.colStrobe_n = 1'b1;
          nxt_step = adrc_pkg::TIMER_ZERO;
        end
      end
      ST_COL_END: begin
        // Row rises after the column, read hold is zero
        nxt_pins.writeStrobe_n = 1'b1;
        if (req_ff.page && accept) begin
          nxt_state = ST_PAGE_PRE;
        end else begin
          nxt_state = ST_ROW_END;
          nxt_pins.rowStrobe_n = 1'b1;
        end
        nxt_step = adrc_pkg::TIMER_ZERO;
      end
      ST_PAGE_PRE: begin
        nxt_pins.addr = req_ff.addr[adrc_pkg::HALF_WIDTH-1:0];
        nxt_pins.writeStrobe_n = (req_ff.cmd != adrc_pkg::ADRC_CMD_WRITE);
        nxt_pins.dataIn = req_ff.wrData;
        if (reached(step_ff, adrc_pkg::CP_CYC)) begin
          nxt_state = ST_COL;
          nxt_pins.colStrobe_n = 1'b0;
          nxt_step = adrc_pkg::TIMER_ZERO;
        end
      end
      ST_ROW_END: begin
        nxt_state = ST_PRECHARGE;
        nxt_step = adrc_pkg::TIMER_ZERO;
      end
      ST_PRECHARGE: begin
        if (reached(step_ff, adrc_pkg::RP_CYC)) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_REF_CAS: begin
        nxt_state = ST_REF_RAS;
        nxt_pins.rowStrobe_n = 1'b0;
        nxt_step = adrc_pkg::TIMER_ZERO;
      end
      ST_REF_RAS: begin
        if (reached(step_ff, adrc_pkg::CHR_CYC)) begin
          nxt_pins.colStrobe_n = 1'b1;
        end
        if (reached(step_ff, adrc_pkg::RAS_CYC)) begin
          nxt_state = ST_ROW_END;
          nxt_pins.rowStrobe_n = 1'b1;
        end
      end
      default: begin
        nxt_state = ST_IDLE;
      end
    endcase
    if (nxt_state == ST_ROW && state_ff == ST_IDLE) begin
      nxt_pins.addr = req.addr[adrc_pkg::ADDR_WIDTH-1:adrc_pkg::HALF_WIDTH];
    end
  end

  // Sequencer state and pins
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ST_POWER;
      step_ff <= adrc_pkg::TIMER_ZERO;
      pins_ff <= '{rowStrobe_n: 1'b1, colStrobe_n: 1'b1, writeStrobe_n: 1'b1, addr: '0, dataIn: 1'b0};
    end else if (clockEnable) begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      pins_ff <= nxt_pins;
    end
  end

  // Wake-up cycle count, also sets init done
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wakeCount_ff <= 4'h0;
      initDone_ff <= 1'b0;
    end else if (clockEnable) begin
      if (state_ff == ST_IDLE && nxt_state == ST_WAKE_LOW) begin
        wakeCount_ff <= 4'h1;
        initDone_ff <= 1'b0;
      end else if (state_ff == ST_POWER && nxt_state == ST_WAKE_LOW) begin
        wakeCount_ff <= 4'h1;
      end else if (state_ff == ST_WAKE_HIGH && nxt_state == ST_WAKE_LOW) begin
        wakeCount_ff <= wakeCount_ff + 4'h1;
      end else if (state_ff == ST_WAKE_HIGH && nxt_state == ST_IDLE) begin
        initDone_ff <= 1'b1;
      end
    end
  end

  // Request handshake: ready only where a new access may start
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reqReady_ff <= 1'b0;
      req_ff <= '0;
    end else if (clockEnable) begin
      if (accept) begin
        req_ff <= req;
      end
      reqReady_ff <= !accept && ((nxt_state == ST_IDLE && !refreshDue_ff && reached(since_ff, adrc_pkg::RC_CYC - 1))
                     || (nxt_state == ST_COL_END && req_ff.page && !refreshDue_ff));
    end
  end

  // Read data captured just before column rises; output floats after
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rdValid_ff <= 1'b0;
      rdData_ff <= 1'b0;
    end else if (clockEnable) begin
      rdValid_ff <= (state_ff == ST_COL_END && req_ff.cmd != adrc_pkg::ADRC_CMD_WRITE);
      if (state_ff == ST_COL_END && req_ff.cmd != adrc_pkg::ADRC_CMD_WRITE) begin
        rdData_ff <= doutSync_ff;
      end
    end
  end

  assign pins = pins_ff;
  assign reqReady = reqReady_ff;
  assign rdValid = rdValid_ff;
  assign rdData = rdData_ff;
  assign initDone = initDone_ff;
endmodule

// ==== verification/adrc_props.sv ====
`timescale 1ns/1ns
// Timing checker on the memory pins
module adrc_props #(
  parameter int POWER_UP_CYCLES = 20,
  parameter int REFRESH_SPACING = 200
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic clockEnable,
  input wire logic reqValid,
  input wire adrc_pkg::adrc_req_s req,
  input wire logic dataOutPin,
  input wire logic reqReady,
  input wire logic rdValid,
  input wire logic rdData,
  input wire logic initDone,
  input wire adrc_pkg::adrc_pins_s pins
);
  logic [15:0] rowLow, colHigh, sinceWr, sinceRw;
  logic [3:0] rowFalls;
  logic colSeen, wrInRow;
  adrc_pkg::adrc_req_s lastReq;
  wire rowN = pins.rowStrobe_n;
  wire colN = pins.colStrobe_n;
  wire wrN = pins.writeStrobe_n;
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  // Cycle counts between strobe edges; sinceWr and sinceRw saturate, rowLow and colHigh wrap
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rowLow <= 16'h0000;
      colHigh <= 16'h0000;
      sinceWr <= 16'hFFFF;
      sinceRw <= 16'hFFFF;
    end else begin
      rowLow <= rowN ? 16'h0000 : rowLow + 16'h0001;
      colHigh <= colN ? colHigh + 16'h0001 : 16'h0000;
      sinceWr <= $fell(wrN) ? 16'h0001 : sinceWr + {15'h0000, sinceWr != 16'hFFFF};
      sinceRw <= ($fell(rowN) && colN && initDone) ? 16'h0001 : sinceRw + {15'h0000, sinceRw != 16'hFFFF};
    end
  end
  // Per-row flags, row-cycle tally and the last request taken
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      rowFalls <= 4'h0;
      colSeen <= 1'b0;
      wrInRow <= 1'b0;
      lastReq <= '0;
    end else begin
      rowFalls <= rowFalls + {3'h0, $fell(rowN) && rowFalls != 4'hF};
      colSeen <= !rowN && (colSeen || !colN);
      wrInRow <= !rowN && (wrInRow || !wrN);
      if (clockEnable && reqValid && reqReady) lastReq <= req;
    end
  end
  a_rcd_window: assert property ($fell(colN) && !rowN && !colSeen |->
    rowLow >= adrc_pkg::RCD_MIN_CYC && rowLow <= adrc_pkg::RCD_MAX_CYC) else $error("column fall outside row window");
  a_page_precharge: assert property ($fell(colN) && !rowN && colSeen |-> colHigh >= adrc_pkg::CP_CYC)
    else $error("page column high too short");
  a_write_lead: assert property ($rose(rowN) && wrInRow |-> sinceWr >= adrc_pkg::RWL_CYC)
    else $error("write strobe too late before row rise");
  a_refresh_hold: assert property ($fell(rowN) && !colN |-> !colN [*3])
    else $error("refresh column hold too short");
  a_cycle_spacing: assert property ($fell(rowN) && colN && initDone |-> sinceRw >= adrc_pkg::RC_CYC)
    else $error("random cycles too close");
  a_row_address: assert property ($fell(rowN) && colN && initDone |-> pins.addr == lastReq.addr[17:9])
    else $error("wrong row half");
  a_early_data: assert property ($fell(colN) && !rowN && !wrN |-> pins.dataIn == lastReq.wrData &&
    pins.addr == lastReq.addr[8:0] ##1 $stable(pins.dataIn) [*4]) else $error("write data or column wrong");
  a_wake_count: assert property ($rose(initDone) |-> rowFalls >= 4'h8)
    else $error("ready before eight row cycles");
  c_late_write: cover property ($fell(wrN) && !colN && !rowN);
  c_refresh: cover property ($fell(rowN) && !colN);
  c_page: cover property ($fell(colN) && !rowN && colSeen);
endmodule

bind adrc_controller adrc_props #(.POWER_UP_CYCLES(POWER_UP_CYCLES), .REFRESH_SPACING(REFRESH_SPACING)) adrc_props_inst (
  .clock(clock), .reset_n(reset_n), .clockEnable(clockEnable), .reqValid(reqValid), .req(req),
  .dataOutPin(dataOutPin), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData), .initDone(initDone),
  .pins(pins));

// ==== verification/adrc_dram_model.sv ====
`timescale 1ns/1ns
// Behavioural 256K x 1 memory; fixed access delay
module adrc_dram_model #(
  parameter int ACCESS_NS = 30,
  parameter int RELEASE_NS = 20
) (
  input wire adrc_pkg::adrc_pins_s pins,
  output logic dataOut
);
  logic cells [0:262143];
  logic [8:0] rowLatch;
  logic [17:0] cellAddr;
  logic [7:0] refreshRow;
  logic readPending;
  initial begin
    dataOut = 1'b0;
    readPending = 1'b0;
    rowLatch = 9'h000;
    cellAddr = 18'h00000;
    refreshRow = 8'h00;
  end
  // Row fall: latch row, or step the own counter when column already low
  always @(negedge pins.rowStrobe_n) begin
    if (!pins.colStrobe_n)
      refreshRow = refreshRow + 8'h01;
    else
      rowLatch = pins.addr;
  end
  // Column fall in a row: early write keeps the line released, else read
  always @(negedge pins.colStrobe_n) begin
    if (!pins.rowStrobe_n) begin
      cellAddr = {rowLatch, pins.addr};
      if (!pins.writeStrobe_n)
        cells[cellAddr] = pins.dataIn;
      else begin
        readPending = 1'b1;
        #(ACCESS_NS);
        readPending = 1'b0;
        if (!pins.colStrobe_n && pins.writeStrobe_n) dataOut = cells[cellAddr];
      end
    end
  end
  // Late write stores data; the output keeps what was read if the read settled first
  always @(negedge pins.writeStrobe_n) begin
    if (!pins.rowStrobe_n && !pins.colStrobe_n) begin
      // Write strobe before the read settled leaves the output undefined
      if (readPending) dataOut = 1'bx;
      cells[cellAddr] = pins.dataIn;
    end
  end
  // Released line shows the inverse so stale data never passes
  always @(posedge pins.colStrobe_n) begin
    #(RELEASE_NS);
    if (pins.colStrobe_n) dataOut = ~dataOut;
  end
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  logic clock, reset_n, reqValid, dataOutPin, reqReady, rdValid, rdData, initDone, d, ce;
  adrc_pkg::adrc_req_s req;
  adrc_pkg::adrc_pins_s pins;
  adrc_pkg::adrc_pins_s held;
  int n_fail, tests_run, i, k;
  logic expQ[$];
  logic shadow [logic [17:0]];
  logic [17:0] addrs [6];
  logic [17:0] b;

  // Free-running 125 MHz clock
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  adrc_controller #(.POWER_UP_CYCLES(20), .REFRESH_SPACING(200)) adrc_controller_inst (
    .clock(clock), .reset_n(reset_n), .clockEnable(ce), .reqValid(reqValid), .req(req),
    .dataOutPin(dataOutPin), .reqReady(reqReady), .rdValid(rdValid), .rdData(rdData),
    .initDone(initDone), .pins(pins));
  adrc_dram_model adrc_dram_model_inst (.pins(pins), .dataOut(dataOutPin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic summarize;
    if (n_fail == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Holds the request until ready is sampled, then notes the expected read bit
  task automatic send(input adrc_pkg::adrc_cmd_e c, input logic pg, input logic [17:0] a, input logic wd);
    int j;
    req <= '{cmd: c, page: pg, addr: a, wrData: wd};
    reqValid <= 1'b1;
    for (j = 0; j < 3000; j++) begin
      @(posedge clock);
      if (reqReady === 1'b1) break;
    end
    if (j == 3000) begin
      n_fail++;
      summarize();
    end
    if (c != adrc_pkg::ADRC_CMD_WRITE) expQ.push_back(shadow[a]);
    if (c != adrc_pkg::ADRC_CMD_READ) shadow[a] = wd;
  endtask

  // Oldest note against each read pulse; a pulse with no note is a fault
  always @(posedge clock) begin
    if (rdValid === 1'b1) begin
      check(expQ.size() > 0, 1'b1);
      if (expQ.size() > 0) check(rdData, expQ.pop_front());
    end
  end

  initial begin
    reset_n = 1'b0;
    reqValid = 1'b0;
    ce = 1'b1;
    req = '0;
    n_fail = 0;
    tests_run = 0;
    void'($urandom(32'h7586));
    repeat (5) @(posedge clock);
    check(pins.rowStrobe_n, 1'b1);
    check(initDone, 1'b0);
    reset_n <= 1'b1;
    // Pause plus eight row cycles come before ready
    for (i = 0; i < 2000; i++) begin
      @(posedge clock);
      if (initDone === 1'b1) break;
    end
    check(i < 2000 && i >= 194, 1'b1);
    if (i == 2000) summarize();
    // Early writes to random cells
    for (k = 0; k < 6; k++) begin
      addrs[k] = 18'($urandom());
      send(adrc_pkg::ADRC_CMD_WRITE, 1'b0, addrs[k], 1'($urandom()));
    end
    // Page pairs in one row, writes then reads back to back
    for (k = 0; k < 3; k++) begin
      b = {addrs[k][17:9], 9'($urandom())};
      d = 1'($urandom());
      send(adrc_pkg::ADRC_CMD_WRITE, 1'b1, addrs[k], ~d);
      send(adrc_pkg::ADRC_CMD_WRITE, 1'b0, b, d);
      send(adrc_pkg::ADRC_CMD_READ, 1'b1, addrs[k], 1'b0);
      send(adrc_pkg::ADRC_CMD_READ, 1'b0, b, 1'b0);
    end
    // Read-modify-write returns the old bit and stores the new
    for (k = 0; k < 6; k++) send(adrc_pkg::ADRC_CMD_RMW, 1'b0, addrs[k], 1'($urandom()));
    reqValid <= 1'b0;
    // Idle across one or two refresh ticks, then data must still read back
    repeat (300) @(posedge clock);
    // Clock enable low: no strobe or address may move
    ce <= 1'b0;
    @(posedge clock);
    held = pins;
    repeat (20) begin
      @(posedge clock);
      check(pins, held);
    end
    ce <= 1'b1;
    repeat (280) @(posedge clock);
    check(initDone, 1'b1);
    for (k = 0; k < 6; k++) send(adrc_pkg::ADRC_CMD_READ, 1'b0, addrs[k], 1'b0);
    reqValid <= 1'b0;
    for (i = 0; i < 200; i++) begin
      @(posedge clock);
      if (expQ.size() == 0) break;
    end
    check(expQ.size(), 0);
    summarize();
  end
endmodule
